// File: core/idl_loader.sv
// Serial write receiver loading twelve channel code registers
`timescale 1ns/100ps
`default_nettype none
module idl_loader
  import idl_pkg::*;
(
  // Clock, reset, enable
  input wire logic ref_clk,
  input wire logic reset_n,
  input wire logic clk_en,
  // Serial bus pins; data is open drain
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  // Address straps
  input wire logic addr_strap_bit0,
  input wire logic addr_strap_bit1,
  input wire logic addr_strap_bit2,
  // Channel codes, channel one in the lowest byte
  output logic [NUM_CHAN-1:0][7:0] dac_code
);

  // ==========================================================
  // Pin sampling
  logic [SYNC_WIDTH-1:0] pin_sync; // Synchronised pins
  logic scl_s;                     // Synchronised clock line
  logic sda_s;                     // Synchronised data line
  logic [2:0] strap_s;             // Synchronised straps

  // At 100 MHz a 400 kHz serial clock gives about 250 samples per bit
  idl_sync #(.W(SYNC_WIDTH)) u_sync (
    .ref_clk(ref_clk),
    .reset_n(reset_n),
    .clk_en(clk_en),
    .pin_in({addr_strap_bit2, addr_strap_bit1, addr_strap_bit0, sda_in, scl_in}),
    .pin_sync(pin_sync)
  );

  assign scl_s = pin_sync[0];
  assign sda_s = pin_sync[1];
  assign strap_s = pin_sync[4:2];

  // ==========================================================
  // Receiver state
  idl_state_t state_reg, state_next;         // Receiver state
  logic scl_q_reg, scl_q_next;               // Clock line one sample back
  logic sda_q_reg, sda_q_next;               // Data line one sample back
  logic [3:0] bit_cnt_reg, bit_cnt_next;     // Bits shifted in this byte
  logic [1:0] byte_idx_reg, byte_idx_next;   // Which byte of the frame
  logic [7:0] shift_reg, shift_next;         // Incoming byte
  logic [7:0] chan_reg, chan_next;           // Channel byte kept for the write
  logic sda_oe_reg, sda_oe_next;             // Pulling data low
  logic [NUM_CHAN-1:0][7:0] dac_code_reg, dac_code_next; // Channel codes

  // Line events, all from synchronised samples
  logic start_det; // Data fell while clock high
  logic stop_det;  // Data rose while clock high
  logic scl_rise;  // Clock rising edge
  logic scl_fall;  // Clock falling edge
  logic byte_done; // Falling edge closing eight bits
  logic wr_commit; // Code byte lands in a channel
  logic [3:0] wr_idx; // Channel register index

  assign start_det = scl_s && scl_q_reg && sda_q_reg && !sda_s;
  assign stop_det = scl_s && scl_q_reg && !sda_q_reg && sda_s;
  assign scl_rise = scl_s && !scl_q_reg;
  assign scl_fall = !scl_s && scl_q_reg;
  assign byte_done = scl_fall && (bit_cnt_reg == BITS_PER_BYTE);
  assign wr_idx = chan_reg[3:0] - CHAN_FIRST;

  // ==========================================================
  // Next state of the receiver
  always_comb begin
    state_next = state_reg;
    scl_q_next = scl_s;
    sda_q_next = sda_s;
    bit_cnt_next = bit_cnt_reg;
    byte_idx_next = byte_idx_reg;
    shift_next = shift_reg;
    chan_next = chan_reg;
    sda_oe_next = sda_oe_reg;
    dac_code_next = dac_code_reg;
    wr_commit = 1'b0;
    if (stop_det) begin
      // Stop ends any frame; a cut-short frame writes nothing
      state_next = ST_IDLE;
      sda_oe_next = 1'b0;
    end else if (start_det) begin
      // Start, repeated or not, restarts the framing
      state_next = ST_RECV;
      bit_cnt_next = '0;
      byte_idx_next = BYTE_ADDR;
      sda_oe_next = 1'b0;
    end else begin
      unique case (state_reg)
        ST_IDLE: begin
          // Nothing until a start
        end
        ST_RECV: begin
          if (scl_rise && (bit_cnt_reg != BITS_PER_BYTE)) begin
            // Sample on the rising edge, first bit is the MSB
            shift_next = {shift_reg[6:0], sda_s};
            bit_cnt_next = bit_cnt_reg + 4'h1;
          end else if (byte_done) begin
            if (byte_idx_reg == BYTE_ADDR) begin
              // Address byte decides whether we take part
              if (addr_hit(shift_reg, strap_s)) begin
                state_next = ST_ACK;
                sda_oe_next = 1'b1;
              end else begin
                state_next = ST_IGNORE;
              end
            end else if (byte_idx_reg == BYTE_CHAN) begin
              // Channel byte: upper nibble is don't care
              chan_next = shift_reg;
              state_next = ST_ACK;
              sda_oe_next = 1'b1;
            end else if (byte_idx_reg == BYTE_DATA) begin
              state_next = ST_ACK;
              sda_oe_next = 1'b1;
              // Unselected nibbles are acked but write nothing
              if (chan_valid(chan_reg)) begin
                wr_commit = 1'b1;
                dac_code_next[wr_idx] = shift_reg;
              end
            end else begin
              // Bytes past the code byte are not acked
              state_next = ST_IGNORE;
            end
          end
        end
        ST_ACK: begin
          // Release at the end of the ack pulse
          if (scl_fall) begin
            state_next = ST_RECV;
            sda_oe_next = 1'b0;
            bit_cnt_next = '0;
            if (byte_idx_reg != 2'h3) begin
              byte_idx_next = byte_idx_reg + 2'h1;
            end
          end
        end
        ST_IGNORE: begin
          // Wait for start or stop
        end
      endcase
    end
  end

  // ==========================================================
  // Registers; the enable freezes everything
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      state_reg <= ST_IDLE;
      scl_q_reg <= 1'b1; // Idle high, same as the synchroniser
      sda_q_reg <= 1'b1; // Idle high, same as the synchroniser
      bit_cnt_reg <= '0;
      byte_idx_reg <= BYTE_ADDR;
      shift_reg <= '0;
      chan_reg <= '0;
      sda_oe_reg <= 1'b0;
      dac_code_reg <= {NUM_CHAN{CODE_RESET}};
    end else if (clk_en) begin
      state_reg <= state_next;
      scl_q_reg <= scl_q_next;
      sda_q_reg <= sda_q_next;
      bit_cnt_reg <= bit_cnt_next;
      byte_idx_reg <= byte_idx_next;
      shift_reg <= shift_next;
      chan_reg <= chan_next;
      sda_oe_reg <= sda_oe_next;
      dac_code_reg <= dac_code_next;
    end
  end

  // Open drain: only ever drive low
  logic sda_out_reg; // Constant low drive value
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      sda_out_reg <= 1'b0;
    end else if (clk_en) begin
      sda_out_reg <= 1'b0;
    end
  end

  assign sda_out = sda_out_reg;
  assign sda_oe = sda_oe_reg;
  assign dac_code = dac_code_reg;

  // ==========================================================
  // Assertions
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!reset_n);

  a_start_detect: assert property (
    clk_en && start_det && !stop_det |=> state_reg == ST_RECV && bit_cnt_reg == 4'h0 && !sda_oe_reg
  ) else $error("Start did not restart the receiver");

  a_stop_idle: assert property (
    clk_en && stop_det |=> state_reg == ST_IDLE && !sda_oe_reg
  ) else $error("Stop did not end the frame");

  a_addr_miss: assert property (
    clk_en && state_reg == ST_RECV && byte_done && byte_idx_reg == BYTE_ADDR && !start_det && !stop_det
      && !addr_hit(shift_reg, strap_s) |=> state_reg == ST_IGNORE && !sda_oe_reg
  ) else $error("Foreign address was acknowledged");

  a_ack_drive: assert property (
    sda_oe_reg == (state_reg == ST_ACK)
  ) else $error("Data pulled low outside the ack");

  a_ack_release: assert property (
    clk_en && state_reg == ST_ACK && scl_fall && !start_det && !stop_det
      |=> state_reg == ST_RECV && !sda_oe_reg && bit_cnt_reg == 4'h0
  ) else $error("Ack not released at clock fall");

  a_chan_range: assert property (
    wr_commit |-> chan_reg[3:0] >= 4'h1 && chan_reg[3:0] <= 4'hc
  ) else $error("Write to an unselected channel");

  a_codes_kept: assert property (
    clk_en && !wr_commit |=> $stable(dac_code_reg)
  ) else $error("Channel code changed without a write");

  a_code_store: assert property (
    clk_en && wr_commit |=> dac_code_reg[$past(wr_idx)] == $past(shift_reg)
  ) else $error("Code byte not stored in its channel");

  a_reset_clear: assert property (
    @(posedge ref_clk) disable iff (1'b0)
    !reset_n |-> dac_code_reg == '0 && state_reg == ST_IDLE && !sda_oe_reg
  ) else $error("Reset did not clear the receiver");

  c_write_first: cover property (wr_commit && chan_reg[3:0] == 4'h1);
  c_write_last: cover property (wr_commit && chan_reg[3:0] == 4'hc);
  c_addr_miss: cover property (state_reg == ST_RECV ##1 state_reg == ST_IGNORE);
  c_no_chan: cover property (byte_done && byte_idx_reg == BYTE_DATA && !chan_valid(chan_reg));

endmodule // idl_loader
`default_nettype wire

// File: core/idl_pkg.sv
// Constants, types and helper functions for the I2C channel code loader
package idl_pkg;

  // ==========================================================
  // Address and byte framing
  localparam logic [3:0] ADDR_PREFIX = 4'h9;   // Fixed upper address bits
  localparam logic [3:0] BITS_PER_BYTE = 4'h8; // Bits shifted before an ack
  localparam logic [1:0] BYTE_ADDR = 2'h0;     // Byte index of the address
  localparam logic [1:0] BYTE_CHAN = 2'h1;     // Byte index of the channel byte
  localparam logic [1:0] BYTE_DATA = 2'h2;     // Byte index of the code byte

  // ==========================================================
  // Channels and reset values
  localparam int NUM_CHAN = 12;                 // Channel holding registers
  localparam logic [3:0] CHAN_FIRST = 4'h1;     // Lowest selecting nibble
  localparam logic [3:0] CHAN_LAST = 4'hc;      // Highest selecting nibble
  localparam logic [7:0] CODE_RESET = 8'h00;    // Code after reset
  localparam int SYNC_WIDTH = 5;                // Pins through the synchroniser

  // ==========================================================
  // Timing: serial clock against the sampling clock
  localparam int CLK_FREQ_KHZ = 100000;         // Sampling clock rate
  localparam int SCL_FAST_KHZ = 400;            // Fastest serial clock
  localparam int SCL_FAST_PERIOD_CYC = CLK_FREQ_KHZ / SCL_FAST_KHZ;

  // Receiver states
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,   // Bus free after reset or a stop
    ST_RECV = 2'b01,   // Shifting a byte in
    ST_ACK = 2'b10,    // Holding data low for the ack pulse
    ST_IGNORE = 2'b11  // Not addressed or past the code byte; wait for start or stop
  } idl_state_t;

  // Address byte hits this device with a write direction
  function automatic logic addr_hit(input logic [7:0] b, input logic [2:0] strap);
    addr_hit = (b[7:1] == {ADDR_PREFIX, strap}) && !b[0];
  endfunction

  // Channel nibble names one of the twelve channels
  function automatic logic chan_valid(input logic [7:0] b);
    chan_valid = (b[3:0] >= CHAN_FIRST) && (b[3:0] <= CHAN_LAST);
  endfunction

endpackage

// File: core/idl_sync.sv
// Two flip-flop synchroniser for asynchronous pin inputs
`timescale 1ns/100ps
`default_nettype none
module idl_sync #(
  parameter int W = 1
) (
  // Clock, reset, enable
  input wire logic ref_clk,
  input wire logic reset_n,
  input wire logic clk_en,
  // Pins in, synchronised out
  input wire logic [W-1:0] pin_in,
  output logic [W-1:0] pin_sync
);

  logic [W-1:0] meta_reg; // First stage, read by the second stage only
  logic [W-1:0] sync_reg; // Second stage, safe to use

  // ==========================================================
  // Two stages; reset to the idle-high bus level so no false edge follows reset
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      meta_reg <= '1;
      sync_reg <= '1;
    end else if (clk_en) begin
      meta_reg <= pin_in;
      sync_reg <= meta_reg;
    end
  end

  assign pin_sync = sync_reg;

endmodule // idl_sync
`default_nettype wire

// File: tb/idl_master.sv
// Bus master model that drives the serial clock and the open-drain data line
`timescale 1ns/100ps
`default_nettype none
module idl_master (
  // Sampling clock
  input wire logic ref_clk,
  // Serial lines; data is released high when sda_drv is 1
  output logic scl,
  output logic sda_drv,
  input wire logic sda_wire
);
  logic got; // Data level sampled at the end of the clock high phase

  initial begin
    scl = 1'b1;
    sda_drv = 1'b1;
  end

  // ==========================================
  // Line sequencing
  // Sampling clock cycles to wait
  task automatic cyc(input int n);
    repeat (n) @(posedge ref_clk);
  endtask

  // Start or repeated start: data falls while the clock is high
  task automatic start_c;
    sda_drv <= 1'b1;
    cyc(3);
    scl <= 1'b1;
    cyc(6);
    sda_drv <= 1'b0;
    cyc(6);
    scl <= 1'b0;
    cyc(3);
  endtask

  // One bit; 120 ns period, the nearest to 125 ns on the 10 ns grid
  task automatic bit_c(input logic b);
    sda_drv <= b;
    cyc(3);
    scl <= 1'b1;
    cyc(6);
    got = sda_wire;
    scl <= 1'b0;
    cyc(3);
  endtask

  // Byte MSB first, then a released ninth bit that reads the ack
  task automatic byte_c(input logic [7:0] v, output logic ack);
    for (int i = 7; i >= 0; i--) begin
      bit_c(v[i]);
    end
    bit_c(1'b1);
    ack = !got;
  endtask

  // Stop: data rises while the clock is high, then bus stays idle
  task automatic stop_c;
    sda_drv <= 1'b0;
    cyc(3);
    scl <= 1'b1;
    cyc(6);
    sda_drv <= 1'b1;
    cyc(6);
  endtask
endmodule // idl_master
`default_nettype wire

// File: tb/idl_loader_tb.sv
// Self-checking bench for the serial channel code loader
`timescale 1ns/100ps
`default_nettype none
module idl_loader_tb;
  import idl_pkg::*;
  logic ref_clk;
  logic reset_n;
  logic clk_en;
  logic [2:0] strap; // Address strap levels
  logic scl;
  logic sda_drv;
  logic sda_out;
  logic sda_oe;
  wire logic sda_wire;
  logic [NUM_CHAN-1:0][7:0] dac_code;
  logic [NUM_CHAN-1:0][7:0] exp_code; // Expected channel codes
  logic [7:0] adr; // Address byte that should hit
  int n_errors;
  int samples_checked;

  // Pull-up wire: low if either party pulls it
  assign sda_wire = sda_drv & ~(sda_oe & ~sda_out);
  assign adr = {ADDR_PREFIX, strap, 1'b0};

  idl_master m (.ref_clk(ref_clk), .scl(scl), .sda_drv(sda_drv), .sda_wire(sda_wire));
  idl_loader dut (.ref_clk(ref_clk), .reset_n(reset_n), .clk_en(clk_en), .scl_in(scl), .sda_in(sda_wire),
    .sda_out(sda_out), .sda_oe(sda_oe), .addr_strap_bit0(strap[0]), .addr_strap_bit1(strap[1]),
    .addr_strap_bit2(strap[2]), .dac_code(dac_code));

  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end

  // ==========================================
  // Checking and verdict
  task automatic check(input logic [NUM_CHAN*8-1:0] seen, input logic [NUM_CHAN*8-1:0] want);
    samples_checked++;
    if (seen !== want) begin
      n_errors++;
      $display("BAD %0t seen %h want %h", $time, seen, want);
    end
  endtask

  task automatic print_verdict;
    if (n_errors == 0 && samples_checked > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  // Full frame; hit says whether the device should answer
  task automatic frame(input logic [7:0] a, input logic [7:0] c, input logic [7:0] d, input logic hit);
    logic ack;
    m.start_c;
    m.byte_c(a, ack);
    check({95'h0, ack}, {95'h0, hit});
    m.byte_c(c, ack);
    check({95'h0, ack}, {95'h0, hit});
    m.byte_c(d, ack);
    check({95'h0, ack}, {95'h0, hit});
    // Only nibbles 1..12 pick a channel
    if (hit && c[3:0] >= 4'h1 && c[3:0] <= 4'hc) begin
      exp_code[c[3:0]-4'h1] = d;
    end
    m.stop_c;
    check(dac_code, exp_code);
  endtask

  // ==========================================
  // Scenarios
  task automatic t_all;
    for (int ch = 1; ch <= 12; ch++) begin
      frame(adr, {4'ha, 4'(ch)}, 8'(ch * 19), 1'b1);
    end
  endtask

  task automatic t_bad_chan;
    logic [3:0] n [4] = '{4'h0, 4'hd, 4'he, 4'hf};
    foreach (n[i]) begin
      frame(adr, {4'h5, n[i]}, 8'h5a, 1'b1);
    end
  endtask

  task automatic t_bad_addr;
    frame({4'h8, strap, 1'b0}, 8'h01, 8'h77, 1'b0);
    frame({4'hb, strap, 1'b0}, 8'h01, 8'h77, 1'b0);
    frame({ADDR_PREFIX, strap ^ 3'h1, 1'b0}, 8'h01, 8'h77, 1'b0);
    frame({ADDR_PREFIX, strap, 1'b1}, 8'h01, 8'h77, 1'b0);
  endtask

  // Frames cut by a stop and by a repeated start leave codes alone
  task automatic t_cut;
    logic ack;
    m.start_c;
    m.byte_c(adr, ack);
    m.byte_c(8'h03, ack);
    // Seven code bits: one short of a write
    for (int i = 0; i < 7; i++) begin
      m.bit_c(i[0]);
    end
    m.stop_c;
    check(dac_code, exp_code);
    m.start_c;
    m.byte_c(adr, ack);
    m.byte_c(8'h01, ack);
    frame(adr, 8'h0c, 8'hff, 1'b1);
  endtask

  // A byte past the code byte is refused and changes nothing
  task automatic t_extra;
    logic ack;
    m.start_c;
    m.byte_c(adr, ack);
    m.byte_c(8'h02, ack);
    m.byte_c(8'h44, ack);
    exp_code[1] = 8'h44;
    m.byte_c(8'h99, ack);
    check({95'h0, ack}, 96'h0);
    m.stop_c;
    check(dac_code, exp_code);
  endtask

  // Enable low freezes the receiver: no ack, no write
  task automatic t_freeze;
    @(posedge ref_clk);
    clk_en <= 1'b0;
    frame(adr, 8'h05, 8'hee, 1'b0);
    @(posedge ref_clk);
    clk_en <= 1'b1;
    m.cyc(4);
  endtask

  // New strap levels move the answering address
  task automatic t_strap;
    logic [7:0] old;
    old = adr;
    @(posedge ref_clk);
    strap <= 3'h5;
    m.cyc(6);
    frame(old, 8'h01, 8'h33, 1'b0);
    frame(adr, 8'h01, 8'h00, 1'b1);
  endtask

  // Reset in mid-run clears every code
  task automatic t_reset_mid;
    @(posedge ref_clk);
    reset_n <= 1'b0;
    m.cyc(2);
    exp_code = '0;
    check(dac_code, exp_code);
    reset_n <= 1'b1;
    m.cyc(4);
    frame(adr, 8'h07, 8'h80, 1'b1);
  endtask

  initial begin
    n_errors = 0;
    samples_checked = 0;
    reset_n = 1'b1;
    clk_en = 1'b1;
    strap = 3'h2;
    exp_code = '0;
    // Reset falls after time zero so the asynchronous branch sees an edge
    #2;
    reset_n = 1'b0;
    repeat (8) @(posedge ref_clk);
    reset_n <= 1'b1;
    repeat (4) @(posedge ref_clk);
    check(dac_code, exp_code);
    t_all;
    t_bad_chan;
    t_bad_addr;
    t_cut;
    t_extra;
    t_strap;
    t_freeze;
    t_reset_mid;
    print_verdict;
  end

  // Watchdog against a hung run
  initial begin
    repeat (90000) @(posedge ref_clk);
    n_errors++;
    print_verdict;
  end
endmodule // idl_loader_tb
`default_nettype wire
